// *** design/eipc_det_if.sv ***
// Link between the register block and one external interrupt detector.
// Assumes one instance per external interrupt input.
`timescale 1ns/10ps
interface eipc_det_if;
    logic pin_level;
    logic polarity;
    logic trigger_type;
    logic vector_ack;
    logic sw_write;
    logic sw_value;
    logic ce;
    logic pending;
    logic event_pulse;

    modport detector (
        input  pin_level,
        input  polarity,
        input  trigger_type,
        input  vector_ack,
        input  sw_write,
        input  sw_value,
        input  ce,
        output pending,
        output event_pulse
    );

    modport control (
        output pin_level,
        output polarity,
        output trigger_type,
        output vector_ack,
        output sw_write,
        output sw_value,
        output ce,
        input  pending,
        input  event_pulse
    );
endinterface : eipc_det_if

// *** design/eipc_ext_detect.sv ***
// One external interrupt detector: polarity, edge or level sense, pending flag.
// Assumes the selected pin is already synchronous to pclk.
`timescale 1ns/10ps
module eipc_ext_detect
    import eipc_pkg::*;
(
    input wire logic      pclk,
    input wire logic      presetn,
    eipc_det_if.detector  det
);
    eipc_det_state_t st_reg;
    eipc_det_state_t st_next;
    logic            active;
    logic            edge_seen;

    // ============================================================
    // Next state
    always_comb begin
        st_next   = st_reg;
        active    = (det.pin_level == det.polarity);
        edge_seen = st_reg.primed & active & ~st_reg.prev_active;
        if (det.ce) begin
            st_next.primed      = 1'b1;
            st_next.prev_active = active;
            st_next.event_pulse = 1'b0;
            if (det.trigger_type) begin
                // Fresh edge beats both software clear and vector clear
                if (edge_seen) begin
                    st_next.pending     = 1'b1;
                    st_next.event_pulse = 1'b1;
                end else if (det.sw_write) begin
                    st_next.pending = det.sw_value;
                end else if (det.vector_ack) begin
                    st_next.pending = 1'b0;
                end
            end else begin
                st_next.pending     = active;
                st_next.event_pulse = active & ~st_reg.pending;
            end
        end
    end

    // ============================================================
    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign det.pending     = st_reg.pending;
    assign det.event_pulse = st_reg.event_pulse;

endmodule : eipc_ext_detect

// *** design/eipc_ext_irq_priority_ctrl.sv ***
// Extended priority registers and the two external interrupt inputs, APB slave.
// Assumes port pins synchronous to pclk and a CPU core that pulses vector acks.
//
// Operation
// - Polarity bit picks active high or low
// - Trigger type bit picks edge or level
// - Type and polarity give four sense modes
// - Inputs watch selected pins, never drive them
// - Pending flags at timer control bits 1, 3
// - Edge mode: vectoring clears pending flag
// - Level mode: pending follows active input level
`timescale 1ns/10ps
`include "eipc_regs.svh"
module eipc_ext_irq_priority_ctrl (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                ce,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire eipc_pkg::eipc_addr_t paddr,
    input  wire eipc_pkg::eipc_data_t pwdata,
    output logic                     pready,
    output eipc_pkg::eipc_data_t     prdata,
    output logic                     pslverr,
    input  wire logic [7:0]          port0_pins,
    input  wire logic                ext0_vector_ack,
    input  wire logic                ext1_vector_ack,
    output logic                     ext_irq_zero_pending,
    output logic                     ext_irq_one_pending,
    output eipc_pkg::eipc_byte_t     prio_one_out,
    output eipc_pkg::eipc_byte_t     prio_two_out,
    output logic                     irq
);
    import eipc_pkg::*;

    // ============================================================
    // Helpers
    function automatic logic pin_select(input logic [7:0] pins, input logic [2:0] sel);
        pin_select = pins[sel];
    endfunction : pin_select

    function automatic logic hit(input eipc_addr_t addr, input eipc_byte_t idx);
        hit = (addr[1:0] == 2'h0) && (addr[11:10] == 2'h0) && (addr[9:2] == idx);
    endfunction : hit

    function automatic logic mapped(input eipc_addr_t addr);
        mapped = hit(addr, `EIPC_PRIO1_IDX) || hit(addr, `EIPC_PRIO2_IDX)
              || hit(addr, `EIPC_CONFIG_IDX) || hit(addr, `EIPC_TIMER_CTL_IDX)
              || hit(addr, `EIPC_STATUS_IDX) || hit(addr, `EIPC_MASK_IDX);
    endfunction : mapped

    // ============================================================
    // Declarations
    eipc_state_t st_reg;
    eipc_state_t st_next;
    eipc_det_if  det_zero ();
    eipc_det_if  det_one ();
    logic        wr_en;
    eipc_byte_t  wbyte;
    eipc_byte_t  timer_ctl_view;
    logic [1:0]  events;

    assign wr_en = psel & penable & pwrite & st_reg.ready & ce;
    assign wbyte = pwdata[7:0];
    assign events = {det_one.event_pulse, det_zero.event_pulse};

    // Pending bits come from the detectors, type bits from registers; bits 7:4 read zero
    always_comb begin
        timer_ctl_view                      = 8'h00;
        timer_ctl_view[`EIPC_TC_TYPE0_BIT] = st_reg.type0;
        timer_ctl_view[`EIPC_TC_PEND0_BIT] = det_zero.pending;
        timer_ctl_view[`EIPC_TC_TYPE1_BIT] = st_reg.type1;
        timer_ctl_view[`EIPC_TC_PEND1_BIT] = det_one.pending;
    end

    // ============================================================
    // Detector hookup
    // Pins are only read here, so whatever the crossbar drives is untouched
    assign det_zero.pin_level    = pin_select(port0_pins,
                                   st_reg.cfg[`EIPC_CF_SEL0_LSB +: 3]);
    assign det_one.pin_level     = pin_select(port0_pins,
                                   st_reg.cfg[`EIPC_CF_SEL1_LSB +: 3]);
    assign det_zero.polarity     = st_reg.cfg[`EIPC_CF_POL0_BIT];
    assign det_one.polarity      = st_reg.cfg[`EIPC_CF_POL1_BIT];
    assign det_zero.trigger_type = st_reg.type0;
    assign det_one.trigger_type  = st_reg.type1;
    assign det_zero.vector_ack   = ext0_vector_ack;
    assign det_one.vector_ack    = ext1_vector_ack;
    assign det_zero.sw_write     = wr_en & hit(paddr, `EIPC_TIMER_CTL_IDX);
    assign det_one.sw_write      = wr_en & hit(paddr, `EIPC_TIMER_CTL_IDX);
    assign det_zero.sw_value     = wbyte[`EIPC_TC_PEND0_BIT];
    assign det_one.sw_value      = wbyte[`EIPC_TC_PEND1_BIT];
    assign det_zero.ce           = ce;
    assign det_one.ce            = ce;

    eipc_ext_detect u_det_zero (
        .pclk    (pclk),
        .presetn (presetn),
        .det     (det_zero.detector)
    );

    eipc_ext_detect u_det_one (
        .pclk    (pclk),
        .presetn (presetn),
        .det     (det_one.detector)
    );

    // ============================================================
    // Bus, registers, interrupt
    always_comb begin
        st_next = st_reg;
        if (ce) begin
            case (st_reg.phase)
                eipc_ph_idle: begin
                    // Read data captured in setup so pready can rise in the first access cycle
                    if (psel && !penable) begin
                        st_next.phase  = eipc_ph_answer;
                        st_next.ready  = 1'b1;
                        st_next.slverr = ~mapped(paddr);
                        st_next.rdata  = 32'h0000_0000;
                        if (!pwrite) begin
                            if (hit(paddr, `EIPC_PRIO1_IDX)) begin
                                st_next.rdata[7:0] = st_reg.prio1;
                            end else if (hit(paddr, `EIPC_PRIO2_IDX)) begin
                                st_next.rdata[7:0] = st_reg.prio2;
                            end else if (hit(paddr, `EIPC_CONFIG_IDX)) begin
                                st_next.rdata[7:0] = st_reg.cfg;
                            end else if (hit(paddr, `EIPC_TIMER_CTL_IDX)) begin
                                st_next.rdata[7:0] = timer_ctl_view;
                            end else if (hit(paddr, `EIPC_STATUS_IDX)) begin
                                st_next.rdata[1:0] = st_reg.status;
                            end else if (hit(paddr, `EIPC_MASK_IDX)) begin
                                st_next.rdata[1:0] = st_reg.mask;
                            end
                        end
                    end
                end
                eipc_ph_answer: begin
                    if (psel && penable) begin
                        st_next.phase  = eipc_ph_idle;
                        st_next.ready  = 1'b0;
                        st_next.slverr = 1'b0;
                        st_next.rdata  = 32'h0000_0000;
                    end
                end
                default: begin
                    st_next.phase = eipc_ph_idle;
                    st_next.ready = 1'b0;
                end
            endcase

            if (wr_en) begin
                if (hit(paddr, `EIPC_PRIO1_IDX)) begin
                    st_next.prio1 = wbyte & `EIPC_PRIO1_MASK;
                end
                if (hit(paddr, `EIPC_PRIO2_IDX)) begin
                    st_next.prio2 = wbyte & `EIPC_PRIO2_MASK;
                end
                if (hit(paddr, `EIPC_CONFIG_IDX)) begin
                    st_next.cfg = wbyte;
                end
                if (hit(paddr, `EIPC_TIMER_CTL_IDX)) begin
                    st_next.type0 = wbyte[`EIPC_TC_TYPE0_BIT];
                    st_next.type1 = wbyte[`EIPC_TC_TYPE1_BIT];
                end
                if (hit(paddr, `EIPC_MASK_IDX)) begin
                    st_next.mask = wbyte[1:0];
                end
                if (hit(paddr, `EIPC_STATUS_IDX)) begin
                    st_next.status = st_reg.status & ~wbyte[1:0];
                end
            end

            // A new event wins over a write-one clear in the same cycle
            st_next.status = st_next.status | events;
            st_next.irq    = |(st_next.status & st_next.mask);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg        <= '0;
            st_reg.phase  <= eipc_ph_idle;
            st_reg.prio1  <= `EIPC_PRIO1_RESET;
            st_reg.prio2  <= `EIPC_PRIO2_RESET;
            st_reg.cfg    <= `EIPC_CONFIG_RESET;
            st_reg.type0  <= `EIPC_TYPE_RESET;
            st_reg.type1  <= `EIPC_TYPE_RESET;
            st_reg.status <= `EIPC_EVENT_RESET;
            st_reg.mask   <= `EIPC_EVENT_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // ============================================================
    // Outputs, all flip-flop driven
    assign pready               = st_reg.ready;
    assign prdata               = st_reg.rdata;
    assign pslverr              = st_reg.slverr;
    assign ext_irq_zero_pending = det_zero.pending;
    assign ext_irq_one_pending  = det_one.pending;
    assign prio_one_out         = st_reg.prio1;
    assign prio_two_out         = st_reg.prio2;
    assign irq                  = st_reg.irq;

endmodule : eipc_ext_irq_priority_ctrl

// *** design/eipc_pkg.sv ***
// Types shared by the external interrupt and priority block.
// Assumes eipc_regs.svh for all numeric values.
package eipc_pkg;

    typedef logic [11:0] eipc_addr_t;
    typedef logic [31:0] eipc_data_t;
    typedef logic [7:0]  eipc_byte_t;

    typedef enum logic {
        eipc_ph_idle,
        eipc_ph_answer
    } eipc_phase_t;

    typedef struct packed {
        logic primed;
        logic prev_active;
        logic pending;
        logic event_pulse;
    } eipc_det_state_t;

    typedef struct packed {
        eipc_phase_t phase;
        logic        ready;
        logic        slverr;
        eipc_data_t  rdata;
        eipc_byte_t  prio1;
        eipc_byte_t  prio2;
        eipc_byte_t  cfg;
        logic        type0;
        logic        type1;
        logic [1:0]  status;
        logic [1:0]  mask;
        logic        irq;
    } eipc_state_t;

endpackage : eipc_pkg

// *** design/eipc_pkg_dummy_never.sv ***
// Holds no code; the shared types live in the package file.

// *** design/eipc_regs.svh ***
// Register map, field positions and reset values of the priority and external interrupt block.
// Assumes inclusion by bare name from files under design/.
`ifndef EIPC_REGS_SVH
`define EIPC_REGS_SVH

// ============================================================
// Register indices (byte address = index * 4)
`define EIPC_PRIO1_IDX     8'hCE
`define EIPC_PRIO2_IDX     8'hCF
`define EIPC_CONFIG_IDX    8'hE4
`define EIPC_TIMER_CTL_IDX 8'hD0
`define EIPC_STATUS_IDX    8'hD1
`define EIPC_MASK_IDX      8'hD2

// ============================================================
// Writable bits and reset values
`define EIPC_PRIO1_MASK    8'hFD
`define EIPC_PRIO2_MASK    8'h02
`define EIPC_PRIO1_RESET   8'h00
`define EIPC_PRIO2_RESET   8'h00
`define EIPC_CONFIG_RESET  8'h01
`define EIPC_TYPE_RESET    1'h0
`define EIPC_EVENT_RESET   2'h0

// ============================================================
// Field positions
`define EIPC_TC_TYPE0_BIT  0
`define EIPC_TC_PEND0_BIT  1
`define EIPC_TC_TYPE1_BIT  2
`define EIPC_TC_PEND1_BIT  3
`define EIPC_CF_SEL0_LSB   0
`define EIPC_CF_POL0_BIT   3
`define EIPC_CF_SEL1_LSB   4
`define EIPC_CF_POL1_BIT   7
`define EIPC_TIMER3_BIT    7
`define EIPC_CMP1_BIT      6
`define EIPC_CMP0_BIT      5
`define EIPC_CNTARR_BIT    4
`define EIPC_CONV_BIT      3
`define EIPC_WINDOW_BIT    2
`define EIPC_TWOWIRE_BIT   0
`define EIPC_PINMATCH_BIT  1

`endif

// *** test/eipc_ext_irq_priority_ctrl_sva.sv ***
// Checker for the priority and external interrupt block.
// Assumes binding to the top module; shadows config and trigger writes itself.
`timescale 1ns/10ps
`include "eipc_regs.svh"
module eipc_ext_irq_priority_ctrl_sva (
    input wire logic                 pclk,
    input wire logic                 presetn,
    input wire logic                 ce,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire eipc_pkg::eipc_addr_t paddr,
    input wire eipc_pkg::eipc_data_t pwdata,
    input wire logic                 pready,
    input wire eipc_pkg::eipc_data_t prdata,
    input wire logic                 pslverr,
    input wire logic [7:0]           port0_pins,
    input wire logic                 ext0_vector_ack,
    input wire logic                 ext1_vector_ack,
    input wire logic                 ext_irq_zero_pending,
    input wire logic                 ext_irq_one_pending,
    input wire eipc_pkg::eipc_byte_t prio_one_out,
    input wire eipc_pkg::eipc_byte_t prio_two_out,
    input wire logic                 irq
);
    import eipc_pkg::*;
    // ============================================================
    // Shadow registers
    localparam eipc_addr_t A_P1  = {2'h0, `EIPC_PRIO1_IDX, 2'h0};
    localparam eipc_addr_t A_CFG = {2'h0, `EIPC_CONFIG_IDX, 2'h0};
    localparam eipc_addr_t A_TC  = {2'h0, `EIPC_TIMER_CTL_IDX, 2'h0};
    eipc_byte_t cfg_q;
    logic       type0_q;
    logic       wr_done;
    logic       act0;
    assign wr_done = psel && penable && pready && pwrite && ce;
    assign act0 = port0_pins[cfg_q[2:0]] == cfg_q[3];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q   <= `EIPC_CONFIG_RESET;
            type0_q <= `EIPC_TYPE_RESET;
        end else if (wr_done && paddr == A_CFG) begin
            cfg_q <= pwdata[7:0];
        end else if (wr_done && paddr == A_TC) begin
            type0_q <= pwdata[`EIPC_TC_TYPE0_BIT];
        end
    end
    // ============================================================
    // Assertions
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable && ce;
    endsequence
    sequence s_write(a);
        wr_done && paddr == a;
    endsequence
    // No pin, config, bus or enable change that could start a new edge
    sequence s_quiet;
        $stable(port0_pins) && $stable(cfg_q) && !psel && ce && $past(ce);
    endsequence
    a_answer_zero_wait:
        assert property (s_setup |=> pready) else $error("no answer in first access cycle");
    a_pready_one_cycle:
        assert property (pready && ce |=> !pready) else $error("pready longer than one cycle");
    a_refuse_misaligned:
        assert property (s_setup ##0 paddr[1:0] != 2'h0 |=> pready && pslverr && prdata == 32'h0)
            else $error("misaligned access not refused");
    a_prdata_upper_zero:
        assert property (pready |-> prdata[31:8] == 24'h0) else $error("read data above byte not zero");
    a_prio_unused_zero:
        assert property ((prio_one_out & ~`EIPC_PRIO1_MASK) == 8'h00 && (prio_two_out & ~`EIPC_PRIO2_MASK) == 8'h00)
            else $error("unused priority bit set");
    a_prio_write_takes:
        assert property (s_write(A_P1) |=> prio_one_out == (eipc_byte_t'($past(pwdata)) & `EIPC_PRIO1_MASK))
            else $error("priority write lost");
    a_edge_ack_clears:
        assert property (type0_q && ext0_vector_ack ##0 s_quiet |=> !ext_irq_zero_pending)
            else $error("vector ack left edge flag set");
    a_level_follows:
        assert property (!type0_q ##0 s_quiet |=> ext_irq_zero_pending == $past(act0))
            else $error("level flag does not follow input");
endmodule : eipc_ext_irq_priority_ctrl_sva

bind eipc_ext_irq_priority_ctrl eipc_ext_irq_priority_ctrl_sva eipc_sva_inst (.pclk, .presetn, .ce, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .port0_pins, .ext0_vector_ack,
    .ext1_vector_ack, .ext_irq_zero_pending, .ext_irq_one_pending, .prio_one_out, .prio_two_out, .irq);

// *** test/eipc_ext_irq_priority_ctrl_tb_top.sv ***
// Self-checking bench for the priority and external interrupt block.
// Assumes the checker is bound in by its own file.
`timescale 1ns/10ps
`include "eipc_regs.svh"
module eipc_ext_irq_priority_ctrl_tb_top;
    import eipc_pkg::*;
    localparam eipc_addr_t A_P1 = {2'h0, `EIPC_PRIO1_IDX, 2'h0};
    localparam eipc_addr_t A_P2 = {2'h0, `EIPC_PRIO2_IDX, 2'h0};
    localparam eipc_addr_t A_CF = {2'h0, `EIPC_CONFIG_IDX, 2'h0};
    localparam eipc_addr_t A_TC = {2'h0, `EIPC_TIMER_CTL_IDX, 2'h0};
    localparam eipc_addr_t A_ST = {2'h0, `EIPC_STATUS_IDX, 2'h0};
    localparam eipc_addr_t A_MK = {2'h0, `EIPC_MASK_IDX, 2'h0};
    logic       pclk = 1'b0;
    logic       presetn = 1'b0;
    logic       psel = 1'b0;
    logic       penable = 1'b0;
    logic       pwrite = 1'b0;
    eipc_addr_t paddr = '0;
    eipc_data_t pwdata = '0;
    logic       ack0 = 1'b0;
    logic       ack1 = 1'b0;
    logic       ce = 1'b1;
    logic       pready, pslverr, pend0, pend1, irq, err;
    eipc_data_t prdata, rd;
    eipc_byte_t prio1, prio2;
    logic [7:0] pins;
    int         errors = 0;
    int         check_count = 0;
    int         cycles = 0;
    always #20 pclk = ~pclk;
    eipc_pin_src eipc_pin_src_inst (.pclk(pclk), .pins(pins));
    eipc_ext_irq_priority_ctrl eipc_ext_irq_priority_ctrl_inst (.pclk(pclk), .presetn(presetn), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .port0_pins(pins), .ext0_vector_ack(ack0),
        .ext1_vector_ack(ack1), .ext_irq_zero_pending(pend0), .ext_irq_one_pending(pend1),
        .prio_one_out(prio1), .prio_two_out(prio2), .irq(irq));
    // ============================================================
    // Tasks
    task automatic check(input string name, input eipc_data_t seen, input eipc_data_t exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic apb(input logic wr, input eipc_addr_t a, input eipc_data_t d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask : settle
    task automatic pulse(input logic which);
        @(posedge pclk);
        ack0 <= !which;
        ack1 <= which;
        @(posedge pclk);
        ack0 <= 1'b0;
        ack1 <= 1'b0;
    endtask : pulse
    task automatic complete_run;
        if (errors == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run
    // Hang guard, well above the few hundred cycles needed
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            complete_run();
        end
    end
    // ============================================================
    // Sequence
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, A_P1, 0); check("prio1 reset", rd, 0);
        apb(0, A_P2, 0); check("prio2 reset", rd, 0);
        apb(0, A_CF, 0); check("config reset", rd, 32'h01);
        apb(0, A_TC, 0); check("timer ctl reset", rd, 0);
        apb(1, A_P1, 32'hFF); apb(0, A_P1, 0); check("prio1 rw", rd, 32'hFD);
        check("prio1 out", {24'h0, prio1}, 32'hFD);
        apb(1, A_P2, 32'hFF); apb(0, A_P2, 0); check("prio2 rw", rd, 32'h02);
        check("prio2 out", {24'h0, prio2}, 32'h02);
        apb(0, 12'h004, 0); check("unmapped err", {31'h0, err}, 1); check("unmapped rd", rd, 0);
        apb(1, A_P1 + 12'h1, 0); check("misaligned err", {31'h0, err}, 1);
        check("misaligned ignored", {24'h0, prio1}, 32'hFD);
        // Four sense modes on input zero, pin 2
        for (int m = 0; m < 4; m++) begin
            eipc_pin_src_inst.set_pin(2, !m[0]);
            apb(1, A_CF, m[0] ? 32'hDA : 32'hD2);
            apb(1, A_TC, {31'h0, m[1]});
            apb(1, A_ST, 32'h3);
            eipc_pin_src_inst.set_pin(2, m[0]);
            settle(3);
            check("pending on", {31'h0, pend0}, 1);
            apb(0, A_TC, 0); check("tc pending", rd, {30'h0, 1'b1, m[1]});
            apb(0, A_ST, 0); check("status event", rd, 1);
            check("irq masked", {31'h0, irq}, 0);
            apb(1, A_MK, 32'h1); settle(2); check("irq on", {31'h0, irq}, 1);
            apb(1, A_ST, 32'h1); settle(2); check("irq cleared", {31'h0, irq}, 0);
            apb(1, A_MK, 0);
            eipc_pin_src_inst.set_pin(2, !m[0]);
            settle(3);
            check("pending off", {31'h0, pend0}, {31'h0, m[1]});
            pulse(0); settle(2); check("pending ack", {31'h0, pend0}, 0);
        end
        // Input one, rising edge on pin 5
        eipc_pin_src_inst.set_pin(2, 1'b1);
        apb(1, A_CF, 32'hD2);
        apb(1, A_TC, 32'h04);
        eipc_pin_src_inst.set_pin(5, 1'b1);
        settle(3);
        check("ext1 pending", {31'h0, pend1}, 1);
        apb(0, A_TC, 0); check("tc ext1", rd, 32'h0C);
        apb(0, A_ST, 0); check("status both", rd, 32'h3);
        pulse(1); settle(2); check("ext1 ack", {31'h0, pend1}, 0);
        // Enable low must hold the level flag still
        @(posedge pclk) ce <= 1'b0;
        eipc_pin_src_inst.set_pin(2, 1'b0);
        settle(3); check("ce frozen", {31'h0, pend0}, 0);
        @(posedge pclk) ce <= 1'b1;
        settle(2); check("ce resumed", {31'h0, pend0}, 1);
        complete_run();
    end
endmodule : eipc_ext_irq_priority_ctrl_tb_top

// *** test/eipc_pin_src.sv ***
// Model of the external interrupt sources at the port pins.
// Assumes the bench calls set_pin; pins are driven push-pull, never released.
`timescale 1ns/10ps
module eipc_pin_src (
    input  wire logic pclk,
    output logic [7:0] pins
);
    // ============================================================
    // Idle high, pin 5 idle low; the block only samples these
    initial pins = 8'hDF;
    // Sets one pin at the next clock edge and holds it until the bench sets it again
    task automatic set_pin(input int idx, input logic val);
        @(posedge pclk);
        pins[idx] <= val;
    endtask : set_pin
endmodule : eipc_pin_src
